// ===== common/stw_defs.svh
`ifndef STW_DEFS_SVH
`define STW_DEFS_SVH
// ==========================================================
// register addresses on the special function register port
`define STW_ADDR_TIMER 8'hBF
`define STW_ADDR_CTRL 8'hC0
`define STW_ADDR_STATUS 8'hC2
`define STW_ADDR_CLKRATE 8'hC3
// ==========================================================
// timer control bit positions
`define STW_TMR_ENABLE_BIT 2
`define STW_TMR_PRESCALE_BIT 1
`define STW_TMR_OVF_BIT 0
// ==========================================================
// control bit positions
`define STW_CTL_ENABLE_BIT 6
`define STW_CTL_START_BIT 5
`define STW_CTL_STOP_BIT 4
`define STW_CTL_IRQ_BIT 3
`define STW_CTL_ACK_BIT 2
// ==========================================================
// reset values and constants
`define STW_CTRL_RESET 8'h00
`define STW_TIMER_RESET 8'h00
`define STW_CLKRATE_RESET 8'h00
`define STW_STATUS_RESET 8'hF8
`define STW_STATUS_IDLE 8'hF8
`define STW_CNT_MAX 14'h3FFF
`define STW_PRESCALE_LAST 2'h3
`endif

// ===== common/stw_pkg.sv
// ==========================================================
// shared types
package stw_pkg;
    typedef enum logic [1:0] {
        STW_BUF_EMPTY = 2'h0,
        STW_BUF_ONE = 2'h1,
        STW_BUF_TWO = 2'h3
    } stw_buf_state_t;
endpackage

// ===== rtl/stw_serial_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "stw_defs.svh"
module stw_serial_ctrl (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic [7:0] eng_status_i,
    input wire logic eng_status_valid_i,
    output logic eng_status_ready_o,
    input wire logic eng_stop_seen_i,
    input wire logic eng_scl_low_i,
    input wire logic eng_sda_low_i,
    output logic eng_scl_line_o,
    output logic eng_sda_line_o,
    output logic slave_addressable_o,
    output logic start_request_o,
    output logic stop_request_o,
    output logic assert_acknowledge_o,
    output logic [7:0] serial_clock_rate_o,
    output logic serial_irq_req_o,
    input wire logic gpio_scl_latch_i,
    input wire logic gpio_sda_latch_i,
    output logic gpio_scl_pin_o,
    output logic gpio_sda_pin_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);
    // ==========================================================
    // helpers
    function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] target);
        sfr_hit = (addr == target);
    endfunction
    // ==========================================================
    // pin synchronisers
    logic [1:0] scl_sync_reg, scl_sync_next;
    logic [1:0] sda_sync_reg, sda_sync_next;
    // second stage is the only stage read by logic
    always_comb begin
        scl_sync_next = {scl_sync_reg[0], scl_i};
        sda_sync_next = {sda_sync_reg[0], sda_i};
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
        end else begin
            scl_sync_reg <= scl_sync_next;
            sda_sync_reg <= sda_sync_next;
        end
    end

    // ==========================================================
    // status buffer, two entries
    stw_pkg::stw_buf_state_t buf_state_reg, buf_state_next;
    logic [7:0] buf_mem_reg [0:1];
    logic [7:0] buf_mem_next [0:1];
    logic buf_wptr_reg, buf_wptr_next;
    logic buf_rptr_reg, buf_rptr_next;
    logic buf_push, buf_pop, buf_out_valid;
    logic [7:0] buf_out_data;
    logic si_reg, si_next;
    logic ens_reg;
    // drained into the status register only while the serial flag is clear
    always_comb begin
        eng_status_ready_o = (buf_state_reg != stw_pkg::STW_BUF_TWO);
        buf_out_valid = (buf_state_reg != stw_pkg::STW_BUF_EMPTY);
        buf_out_data = buf_mem_reg[buf_rptr_reg];
        buf_push = eng_status_valid_i && eng_status_ready_o;
        buf_pop = buf_out_valid && !si_reg && ens_reg;
        buf_mem_next = buf_mem_reg;
        buf_wptr_next = buf_wptr_reg;
        buf_rptr_next = buf_rptr_reg;
        buf_state_next = buf_state_reg;
        if (buf_push) begin
            buf_mem_next[buf_wptr_reg] = eng_status_i;
            buf_wptr_next = !buf_wptr_reg;
        end
        if (buf_pop) begin
            buf_rptr_next = !buf_rptr_reg;
        end
        case ({buf_push, buf_pop})
            2'h2: begin
                buf_state_next = (buf_state_reg == stw_pkg::STW_BUF_EMPTY) ?
                    stw_pkg::STW_BUF_ONE : stw_pkg::STW_BUF_TWO;
            end
            2'h1: begin
                buf_state_next = (buf_state_reg == stw_pkg::STW_BUF_TWO) ?
                    stw_pkg::STW_BUF_ONE : stw_pkg::STW_BUF_EMPTY;
            end
            default: begin
                buf_state_next = buf_state_reg;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            buf_state_reg <= stw_pkg::STW_BUF_EMPTY;
            buf_mem_reg[0] <= 8'h00;
            buf_mem_reg[1] <= 8'h00;
            buf_wptr_reg <= 1'b0;
            buf_rptr_reg <= 1'b0;
        end else begin
            buf_state_reg <= buf_state_next;
            buf_mem_reg <= buf_mem_next;
            buf_wptr_reg <= buf_wptr_next;
            buf_rptr_reg <= buf_rptr_next;
        end
    end

    // ==========================================================
    // control, status and clock-rate registers
    logic ens_next, sta_reg, sta_next, sto_reg, sto_next, aa_reg, aa_next;
    logic [7:0] status_reg, status_next, clkrate_reg, clkrate_next;
    logic wr_ctrl, si_set;
    always_comb begin
        wr_ctrl = sfr_wr_i && sfr_hit(sfr_addr_i, `STW_ADDR_CTRL);
        si_set = buf_pop && (buf_out_data != `STW_STATUS_IDLE);
        ens_next = ens_reg;
        sta_next = sta_reg;
        sto_next = sto_reg;
        aa_next = aa_reg;
        si_next = si_reg;
        status_next = buf_pop ? buf_out_data : status_reg;
        clkrate_next = clkrate_reg;
        if (wr_ctrl) begin
            ens_next = sfr_wdata_i[`STW_CTL_ENABLE_BIT];
            sta_next = sfr_wdata_i[`STW_CTL_START_BIT];
            sto_next = sfr_wdata_i[`STW_CTL_STOP_BIT];
            aa_next = sfr_wdata_i[`STW_CTL_ACK_BIT];
            if (!sfr_wdata_i[`STW_CTL_IRQ_BIT]) begin
                si_next = 1'b0;
            end
        end
        if (sfr_wr_i && sfr_hit(sfr_addr_i, `STW_ADDR_CLKRATE)) begin
            clkrate_next = sfr_wdata_i;
        end
        if (eng_stop_seen_i) begin
            sto_next = 1'b0;
        end
        if (!ens_next) begin
            sto_next = 1'b0;
        end
        if (si_set) begin
            si_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ens_reg <= 1'(`STW_CTRL_RESET >> `STW_CTL_ENABLE_BIT);
            sta_reg <= 1'b0;
            sto_reg <= 1'b0;
            aa_reg <= 1'b0;
            si_reg <= 1'b0;
            status_reg <= `STW_STATUS_RESET;
            clkrate_reg <= `STW_CLKRATE_RESET;
        end else begin
            ens_reg <= ens_next;
            sta_reg <= sta_next;
            sto_reg <= sto_next;
            aa_reg <= aa_next;
            si_reg <= si_next;
            status_reg <= status_next;
            clkrate_reg <= clkrate_next;
        end
    end

    // ==========================================================
    // timeout counter with prescaler
    logic timeout_timer_enable_reg, timeout_timer_enable_next, timer_prescale_select_reg, timer_prescale_select_next, tif_reg, tif_next;
    logic [13:0] cnt_reg, cnt_next;
    logic [1:0] pre_reg, pre_next;
    logic run, tick;
    always_comb begin
        run = timeout_timer_enable_reg && ens_reg && !si_reg;
        tick = timer_prescale_select_reg ? (pre_reg == `STW_PRESCALE_LAST) : 1'b1;
        timeout_timer_enable_next = timeout_timer_enable_reg;
        timer_prescale_select_next = timer_prescale_select_reg;
        tif_next = tif_reg;
        pre_next = run ? 2'(pre_reg + 2'h1) : 2'h0;
        cnt_next = cnt_reg;
        if (sfr_wr_i && sfr_hit(sfr_addr_i, `STW_ADDR_TIMER)) begin
            timeout_timer_enable_next = sfr_wdata_i[`STW_TMR_ENABLE_BIT];
            timer_prescale_select_next = sfr_wdata_i[`STW_TMR_PRESCALE_BIT];
            if (!sfr_wdata_i[`STW_TMR_OVF_BIT]) begin
                tif_next = 1'b0;
            end
        end
        if (si_reg || si_set) begin
            cnt_next = 14'h0000;
            pre_next = 2'h0;
        end else if (run && tick) begin
            cnt_next = cnt_reg + 14'h0001;
            if (cnt_reg == `STW_CNT_MAX) begin
                tif_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            timeout_timer_enable_reg <= 1'b0;
            timer_prescale_select_reg <= 1'b0;
            tif_reg <= 1'b0;
            cnt_reg <= 14'h0000;
            pre_reg <= 2'h0;
        end else begin
            timeout_timer_enable_reg <= timeout_timer_enable_next;
            timer_prescale_select_reg <= timer_prescale_select_next;
            tif_reg <= tif_next;
            cnt_reg <= cnt_next;
            pre_reg <= pre_next;
        end
    end

    // ==========================================================
    // read data and pin drive
    logic [7:0] rdata_reg, rdata_next;
    logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
    always_comb begin
        rdata_next = rdata_reg;
        if (sfr_rd_i) begin
            rdata_next = 8'h00;
            if (sfr_hit(sfr_addr_i, `STW_ADDR_TIMER)) begin
                rdata_next = {5'h00, timeout_timer_enable_reg, timer_prescale_select_reg, tif_reg};
            end else if (sfr_hit(sfr_addr_i, `STW_ADDR_CTRL)) begin
                rdata_next = {1'b0, ens_reg, sta_reg, sto_reg, si_reg, aa_reg, 2'h0};
            end else if (sfr_hit(sfr_addr_i, `STW_ADDR_STATUS)) begin
                rdata_next = status_reg;
            end else if (sfr_hit(sfr_addr_i, `STW_ADDR_CLKRATE)) begin
                rdata_next = clkrate_reg;
            end
        end
        if (ens_reg) begin
            // stretch starts on a low line, then holds until the flag clears
            scl_oe_next = eng_scl_low_i || (si_reg && (!scl_sync_reg[1] || scl_oe_reg));
            sda_oe_next = eng_sda_low_i;
        end else begin
            scl_oe_next = !gpio_scl_latch_i;
            sda_oe_next = !gpio_sda_latch_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 8'h00;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            scl_oe_reg <= scl_oe_next;
            sda_oe_reg <= sda_oe_next;
        end
    end

    // ==========================================================
    // outputs
    assign sfr_rdata_o = rdata_reg;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_oe_reg;
    assign sda_oe_o = sda_oe_reg;
    assign eng_scl_line_o = ens_reg ? scl_sync_reg[1] : 1'b1;
    assign eng_sda_line_o = ens_reg ? sda_sync_reg[1] : 1'b1;
    assign gpio_scl_pin_o = scl_sync_reg[1];
    assign gpio_sda_pin_o = sda_sync_reg[1];
    assign slave_addressable_o = ens_reg;
    assign start_request_o = sta_reg;
    assign stop_request_o = sto_reg;
    assign assert_acknowledge_o = aa_reg;
    assign serial_clock_rate_o = clkrate_reg;
    assign serial_irq_req_o = si_reg || tif_reg;
endmodule
`default_nettype wire

// ===== verification/stw_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "stw_defs.svh"
// ====
// port checker of the serial control block
module stw_checker (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] eng_status_i,
    input wire logic eng_status_valid_i,
    input wire logic eng_status_ready_o,
    input wire logic eng_stop_seen_i,
    input wire logic stop_request_o,
    input wire logic slave_addressable_o,
    input wire logic [7:0] serial_clock_rate_o,
    input wire logic serial_irq_req_o,
    input wire logic eng_scl_line_o,
    input wire logic eng_sda_line_o,
    input wire logic gpio_scl_latch_i,
    input wire logic scl_oe_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // a real code taken while the block can act on it
    sequence take_s;
        slave_addressable_o && !serial_irq_req_o && eng_status_valid_i
            && eng_status_ready_o && eng_status_i != `STW_STATUS_IDLE;
    endsequence
    sequence off_s;
        (!slave_addressable_o)[*3];
    endsequence
    // ====
    // assertions
    status_flag_a: assert property (take_s |-> ##[1:4] serial_irq_req_o)
        else $error("flag not raised");
    lines_idle_a: assert property (off_s |-> eng_scl_line_o && eng_sda_line_o)
        else $error("line seen while off");
    stop_forced_a: assert property (!$past(slave_addressable_o) && !slave_addressable_o
        |-> !stop_request_o) else $error("stop kept while off");
    gpio_drive_a: assert property (!$past(slave_addressable_o) && !slave_addressable_o
        |-> scl_oe_o == !$past(gpio_scl_latch_i)) else $error("gpio drive wrong");
    stop_clear_a: assert property (stop_request_o && eng_stop_seen_i && !sfr_wr_i
        |=> !stop_request_o) else $error("stop not cleared");
    flag_hold_a: assert property (serial_irq_req_o && !sfr_wr_i |=> serial_irq_req_o)
        else $error("flag lost");
    rate_write_a: assert property (sfr_wr_i && sfr_addr_i == `STW_ADDR_CLKRATE
        |=> serial_clock_rate_o == $past(sfr_wdata_i)) else $error("rate not written");
    idle_quiet_a: assert property (!slave_addressable_o && !serial_irq_req_o && !sfr_wr_i
        |=> !serial_irq_req_o) else $error("request while off");
endmodule

bind stw_serial_ctrl stw_checker u_chk (.clk_sys_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i,
    .sfr_wdata_i, .eng_status_i, .eng_status_valid_i, .eng_status_ready_o, .eng_stop_seen_i,
    .stop_request_o, .slave_addressable_o, .serial_clock_rate_o, .serial_irq_req_o,
    .eng_scl_line_o, .eng_sda_line_o, .gpio_scl_latch_i, .scl_oe_o);
`default_nettype wire

// ===== verification/stw_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// other bus parties on open-drain lines with pull-ups
module stw_bus_peer (
    input wire logic pull_scl_i,
    input wire logic pull_sda_i,
    input wire logic dut_scl_oe_i,
    input wire logic dut_sda_oe_i,
    output logic scl_o,
    output logic sda_o
);
    // a released line floats to the pull-up level
    assign scl_o = !(pull_scl_i || dut_scl_oe_i);
    assign sda_o = !(pull_sda_i || dut_sda_oe_i);
endmodule
`default_nettype wire

// ===== verification/stw_serial_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "stw_defs.svh"
// ====
// bench top
module stw_serial_ctrl_tb_top;
    localparam logic [7:0] a_tm = `STW_ADDR_TIMER;
    localparam logic [7:0] a_ct = `STW_ADDR_CTRL;
    localparam logic [7:0] a_st = `STW_ADDR_STATUS;
    localparam int full = int'(`STW_CNT_MAX) + 1;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
    logic eng_status_valid_i = 1'b0, eng_stop_seen_i = 1'b0, eng_scl_low_i = 1'b0;
    logic eng_sda_low_i = 1'b0, gpio_scl_latch_i = 1'b1, gpio_sda_latch_i = 1'b1;
    logic pull_scl = 1'b0, pull_sda = 1'b0, scl_w, sda_w;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, eng_status_i = 8'h00;
    logic [7:0] rv, sfr_rdata_o, serial_clock_rate_o;
    logic eng_status_ready_o, eng_scl_line_o, eng_sda_line_o, slave_addressable_o;
    logic start_request_o, stop_request_o, assert_acknowledge_o, serial_irq_req_o;
    logic gpio_scl_pin_o, gpio_sda_pin_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
    logic [7:0] q_exp[$];
    logic [7:0] ra[5] = '{8'hBF, 8'hC0, 8'hC1, 8'hC2, 8'hC3};
    logic [7:0] rx[5] = '{8'h00, 8'h00, 8'h00, 8'hF8, 8'h00};
    int mismatches = 0, checks_done = 0, n;
    // design and the other bus parties
    stw_serial_ctrl dut (.clk_sys_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
        .sfr_wdata_i, .sfr_rdata_o, .eng_status_i, .eng_status_valid_i, .eng_status_ready_o,
        .eng_stop_seen_i, .eng_scl_low_i, .eng_sda_low_i, .eng_scl_line_o, .eng_sda_line_o,
        .slave_addressable_o, .start_request_o, .stop_request_o, .assert_acknowledge_o,
        .serial_clock_rate_o, .serial_irq_req_o, .gpio_scl_latch_i, .gpio_sda_latch_i,
        .gpio_scl_pin_o, .gpio_sda_pin_o, .scl_i(scl_w), .scl_o, .scl_oe_o, .sda_i(sda_w),
        .sda_o, .sda_oe_o);
    stw_bus_peer peer (.pull_scl_i(pull_scl), .pull_sda_i(pull_sda),
        .dut_scl_oe_i(scl_oe_o), .dut_sda_oe_i(sda_oe_o), .scl_o(scl_w), .sda_o(sda_w));
    // 50 MHz clock
    always #10 clk_sys_i = ~clk_sys_i;
    // ====
    // report and compare
    task results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task chk(input string m, input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task chk_span(input string m, input int g, input int lo, input int hi);
        checks_done++;
        if (g < lo || g > hi) begin
            mismatches++;
            $display("mismatch %0t %s count %0d", $time, m, g);
        end
    endtask
    // ====
    // register port and status stream drivers
    task run(input int k);
        repeat (k) @(negedge clk_sys_i);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        run(1);
        sfr_wr_i = 1'b0;
        run(1);
    endtask
    task rc(input logic [7:0] a, input logic [7:0] e, input string m);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        run(1);
        sfr_rd_i = 1'b0;
        run(1);
        chk(m, sfr_rdata_o, e);
    endtask
    task push(input logic [7:0] c[$]);
        foreach (c[i]) begin
            eng_status_i = c[i];
            eng_status_valid_i = 1'b1;
            if (c[i] != `STW_STATUS_IDLE) q_exp.push_back(c[i]);
            run(1);
        end
        eng_status_valid_i = 1'b0;
    endtask
    task wait_irq(input int lim);
        n = 0;
        while (serial_irq_req_o !== 1'b1) begin
            if (n >= lim) begin
                mismatches++;
                $display("mismatch %0t no interrupt", $time);
                results();
            end
            run(1);
            n++;
        end
    endtask
    // ====
    // main sequence
    initial begin
        void'($urandom(75632));
        run(10);
        rst_n_i = 1'b1;
        foreach (ra[i]) rc(ra[i], rx[i], "reset value");
        repeat (4) begin
            rv = 8'($urandom);
            wr(`STW_ADDR_CLKRATE, rv);
            chk("rate out", serial_clock_rate_o, rv);
            rc(`STW_ADDR_CLKRATE, rv, "rate read");
        end
        $display("test registers done");
        wr(a_ct, 8'h34);
        rc(a_ct, 8'h24, "stop forced");
        chk("addressable", slave_addressable_o, 8'h00);
        chk("ack kept", assert_acknowledge_o, 8'h01);
        gpio_scl_latch_i = 1'b0;
        pull_sda = 1'b1;
        eng_sda_low_i = 1'b1;
        run(3);
        chk("gpio scl", scl_oe_o, 8'h01);
        chk("scl pin", gpio_scl_pin_o, 8'h00);
        chk("sda free", sda_oe_o, 8'h00);
        chk("sda pin", gpio_sda_pin_o, 8'h00);
        chk("sda ignored", eng_sda_line_o, 8'h01);
        chk("scl ignored", eng_scl_line_o, 8'h01);
        chk("pins low", {6'h00, scl_o, sda_o}, 8'h00);
        gpio_scl_latch_i = 1'b1;
        pull_sda = 1'b0;
        eng_sda_low_i = 1'b0;
        run(3);
        wr(a_ct, 8'h74);
        chk("stop set", stop_request_o, 8'h01);
        eng_stop_seen_i = 1'b1;
        run(1);
        eng_stop_seen_i = 1'b0;
        chk("stop cleared", stop_request_o, 8'h00);
        chk("start kept", start_request_o, 8'h01);
        wr(a_ct, 8'h44);
        $display("test pins done");
        push('{8'hF8});
        run(3);
        rc(a_ct, 8'h44, "idle code");
        push('{8'h08, 8'h10, 8'h18});
        chk("buffer full", eng_status_ready_o, 8'h00);
        rc(a_st, q_exp.pop_front(), "code");
        rc(a_ct, 8'h4C, "flag set");
        pull_scl = 1'b1;
        run(2);
        pull_scl = 1'b0;
        run(2);
        chk("stretch", scl_w, 8'h00);
        run(1);
        chk("stretch held", scl_w, 8'h00);
        chk("line low", eng_scl_line_o, 8'h00);
        repeat (2) begin
            wr(a_ct, 8'h44);
            run(2);
            rc(a_st, q_exp.pop_front(), "next code");
        end
        wr(a_ct, 8'h44);
        run(3);
        chk("released", scl_w, 8'h01);
        chk("no request", serial_irq_req_o, 8'h00);
        $display("test status done");
        wr(a_tm, 8'h04);
        run(10000);
        wr(a_tm, 8'h00);
        run(100);
        chk("paused", serial_irq_req_o, 8'h00);
        wr(a_tm, 8'h04);
        wait_irq(20000);
        chk_span("rest", n, full - 10006, full - 9996);
        rc(a_tm, 8'h05, "overflow");
        wr(a_tm, 8'h00);
        rc(a_tm, 8'h00, "cleared");
        $display("test timer done");
        wr(a_tm, 8'h04);
        run(1000);
        push('{8'h20});
        run(3);
        rc(a_st, q_exp.pop_front(), "code");
        wr(a_tm, 8'h06);
        wr(a_ct, 8'h44);
        wait_irq(70000);
        chk_span("divided", n, full * 4 - 8, full * 4 + 4);
        rc(a_tm, 8'h07, "overflow");
        $display("test prescale done");
        results();
    end
endmodule
`default_nettype wire
